// ### design/port_io_exec.sv
// Executor for the port input/output instructions of a byte-wide CPU.
// Assumes the opcode bytes and register values arrive with START; one T state per clock.
`timescale 1ns/1ns
`default_nettype none

module port_io_exec (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic        START,
  input  wire logic [7:0]  OP_BYTE0,
  input  wire logic [7:0]  OP_BYTE1,
  input  wire logic [7:0]  IN_A,
  input  wire logic [7:0]  IN_B,
  input  wire logic [7:0]  IN_C,
  input  wire logic [7:0]  IN_D,
  input  wire logic [7:0]  IN_E,
  input  wire logic [15:0] IN_POINTER_PAIR,
  input  wire logic [7:0]  IN_FLAGS,
  input  wire logic [15:0] IN_PROGRAM_COUNTER,
  input  wire logic        INT_PENDING,
  input  wire logic [7:0]  DATA_IN,
  output logic             BUSY,
  output logic             DONE,
  output logic             ILLEGAL,
  output logic             INT_TAKEN,
  output logic [7:0]       OUT_B,
  output logic [15:0]      OUT_POINTER_PAIR,
  output logic [7:0]       OUT_FLAGS,
  output logic [15:0]      OUT_PROGRAM_COUNTER,
  output logic [15:0]      ADDR,
  output logic [7:0]       DATA_OUT,
  output logic             DATA_OE,
  output logic             MREQ_N,
  output logic             IORQ_N,
  output logic             RD_N,
  output logic             WR_N,
  output logic             RFSH_N
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  port_io_pkg::state_t state_reg, state_next;
  port_io_pkg::class_t cls_reg, cls_next;
  logic        dec_reg, dec_next;
  logic        rep_reg, rep_next;
  logic [7:0]  a_reg, a_next;
  logic [7:0]  b_reg, b_next;
  logic [7:0]  port_reg, port_next;
  logic [7:0]  data_reg, data_next;
  logic [7:0]  f_reg, f_next;
  logic [15:0] pointer_pair_reg, pointer_pair_next;
  logic [15:0] program_counter_reg, program_counter_next;
  logic        done_reg, done_next;
  logic        ill_reg, ill_next;
  logic        int_reg, int_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0]  dout_reg, dout_next;
  logic        oe_reg, oe_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [2:0]  t_len;
  logic [2:0]  t_count;
  logic        t_last;
  logic [7:0]  sel_byte;

  tstate_timer #(
    .W(3)
  ) u_timer (
    .clock (CLOCK),
    .rstn  (RSTN),
    .load  (state_next != state_reg),
    .len   (t_len),
    .count (t_count),
    .last  (t_last)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Source register for register-port output

  always_comb
  begin
    case (OP_BYTE1[5:3])
      port_io_pkg::SEL_B: sel_byte = IN_B;
      port_io_pkg::SEL_C: sel_byte = IN_C;
      port_io_pkg::SEL_D: sel_byte = IN_D;
      port_io_pkg::SEL_E: sel_byte = IN_E;
      port_io_pkg::SEL_H: sel_byte = IN_POINTER_PAIR[15:8];
      port_io_pkg::SEL_L: sel_byte = IN_POINTER_PAIR[7:0];
      port_io_pkg::SEL_A: sel_byte = IN_A;
      default:            sel_byte = port_io_pkg::RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer and datapath

  always_comb
  begin
    state_next           = state_reg;
    cls_next             = cls_reg;
    dec_next             = dec_reg;
    rep_next             = rep_reg;
    a_next               = a_reg;
    b_next               = b_reg;
    port_next            = port_reg;
    data_next            = data_reg;
    f_next               = f_reg;
    pointer_pair_next    = pointer_pair_reg;
    program_counter_next = program_counter_reg;
    done_next            = 1'b0;
    ill_next             = 1'b0;
    int_next             = 1'b0;
    case (state_reg)
      port_io_pkg::ST_IDLE:
        if (START)
        begin
          a_next               = IN_A;
          b_next               = IN_B;
          port_next            = IN_C;
          f_next               = IN_FLAGS;
          pointer_pair_next    = IN_POINTER_PAIR;
          program_counter_next = IN_PROGRAM_COUNTER;
          dec_next             = OP_BYTE1[port_io_pkg::OPC_DEC_BIT];
          rep_next             = OP_BYTE1[port_io_pkg::OPC_REP_BIT];
          state_next           = port_io_pkg::ST_FETCH1;
          if (OP_BYTE0 == port_io_pkg::OPC_OUT_IMM)
          begin
            cls_next  = port_io_pkg::CLS_OUT_IMM;
            port_next = OP_BYTE1;
            data_next = IN_A;
          end
          else if (OP_BYTE0 != port_io_pkg::OPC_PREFIX)
          begin
            ill_next   = 1'b1;
            state_next = port_io_pkg::ST_IDLE;
          end
          else if (OP_BYTE1 == port_io_pkg::OPC_IN_INC_S ||
                   OP_BYTE1 == port_io_pkg::OPC_IN_DEC_S ||
                   OP_BYTE1 == port_io_pkg::OPC_IN_INC_R ||
                   OP_BYTE1 == port_io_pkg::OPC_IN_DEC_R)
            cls_next = port_io_pkg::CLS_IN_BLOCK;
          else if (OP_BYTE1 == port_io_pkg::OPC_OUT_INC_S)
          begin
            cls_next = port_io_pkg::CLS_OUT_INC;
            dec_next = 1'b0;
            rep_next = 1'b0;
          end
          else if ((OP_BYTE1 & port_io_pkg::OPC_REG_MASK) == port_io_pkg::OPC_OUT_REG &&
                   OP_BYTE1[5:3] != 3'h6)
          begin
            cls_next  = port_io_pkg::CLS_OUT_REG;
            data_next = sel_byte;
          end
          else
          begin
            ill_next   = 1'b1;
            state_next = port_io_pkg::ST_IDLE;
          end
        end
      port_io_pkg::ST_FETCH1:
        if (t_last)
          state_next = port_io_pkg::ST_FETCH2;
      port_io_pkg::ST_FETCH2:
        if (t_last)
          case (cls_reg)
            port_io_pkg::CLS_IN_BLOCK: state_next = port_io_pkg::ST_IO_READ;
            port_io_pkg::CLS_OUT_INC:  state_next = port_io_pkg::ST_MEM_READ;
            default:                   state_next = port_io_pkg::ST_IO_WRITE;
          endcase
      port_io_pkg::ST_IO_READ:
        if (t_last)
        begin
          data_next  = DATA_IN;
          state_next = port_io_pkg::ST_MEM_WRITE;
        end
      port_io_pkg::ST_MEM_WRITE:
        if (t_last)
        begin
          b_next = b_reg - 8'h0001;
          if (dec_reg)
            pointer_pair_next = pointer_pair_reg - 16'h0001;
          else
            pointer_pair_next = pointer_pair_reg + 16'h0001;
          f_next[port_io_pkg::FLAG_Z] = (b_next == port_io_pkg::RST_BYTE);
          f_next[port_io_pkg::FLAG_N] = 1'b1;
          if (rep_reg && b_next != port_io_pkg::RST_BYTE)
            state_next = port_io_pkg::ST_REFRESH;
          else
          begin
            state_next = port_io_pkg::ST_IDLE;
            done_next  = 1'b1;
          end
        end
      port_io_pkg::ST_MEM_READ:
        if (t_last)
        begin
          data_next  = DATA_IN;
          b_next     = b_reg - 8'h0001;
          state_next = port_io_pkg::ST_IO_WRITE;
        end
      port_io_pkg::ST_IO_WRITE:
        if (t_last)
        begin
          if (cls_reg == port_io_pkg::CLS_OUT_INC)
          begin
            pointer_pair_next = pointer_pair_reg + 16'h0001;
            f_next[port_io_pkg::FLAG_Z] = (b_reg == port_io_pkg::RST_BYTE);
            f_next[port_io_pkg::FLAG_N] = 1'b1;
          end
          state_next = port_io_pkg::ST_IDLE;
          done_next  = 1'b1;
        end
      port_io_pkg::ST_REFRESH:
        if (t_last)
        begin
          if (INT_PENDING)
          begin
            program_counter_next = program_counter_reg - port_io_pkg::PROG_REWIND;
            int_next             = 1'b1;
            done_next            = 1'b1;
            state_next           = port_io_pkg::ST_IDLE;
          end
          else
            state_next = port_io_pkg::ST_FETCH1;
        end
      default:
        state_next = port_io_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Machine cycle lengths and registered bus values

  always_comb
  begin
    case (state_next)
      port_io_pkg::ST_FETCH2:
        case (cls_next)
          port_io_pkg::CLS_OUT_IMM: t_len = port_io_pkg::LEN_OPERAND;
          port_io_pkg::CLS_OUT_REG: t_len = port_io_pkg::LEN_FETCH_REG;
          default:                  t_len = port_io_pkg::LEN_FETCH_BLK;
        endcase
      port_io_pkg::ST_IO_READ:   t_len = port_io_pkg::LEN_IO_READ;
      port_io_pkg::ST_MEM_WRITE: t_len = port_io_pkg::LEN_MEM_WRITE;
      port_io_pkg::ST_MEM_READ:  t_len = port_io_pkg::LEN_MEM_READ;
      port_io_pkg::ST_IO_WRITE:  t_len = port_io_pkg::LEN_IO_WRITE;
      port_io_pkg::ST_REFRESH:   t_len = port_io_pkg::LEN_REFRESH;
      default:                   t_len = port_io_pkg::LEN_FETCH;
    endcase
    addr_next = port_io_pkg::RST_WORD;
    dout_next = port_io_pkg::RST_BYTE;
    oe_next   = 1'b0;
    case (state_next)
      port_io_pkg::ST_IO_READ:
        addr_next = {b_next, port_next};
      port_io_pkg::ST_IO_WRITE:
      begin
        if (cls_next == port_io_pkg::CLS_OUT_IMM)
          addr_next = {a_next, port_next};
        else
          addr_next = {b_next, port_next};
        dout_next = data_next;
        oe_next   = 1'b1;
      end
      port_io_pkg::ST_MEM_WRITE:
      begin
        addr_next = pointer_pair_next;
        dout_next = data_next;
        oe_next   = 1'b1;
      end
      port_io_pkg::ST_MEM_READ:
        addr_next = pointer_pair_next;
      default:
        addr_next = port_io_pkg::RST_WORD;
    endcase
    cnt_next = (state_reg == port_io_pkg::ST_IDLE || state_reg == port_io_pkg::ST_REFRESH) ?
               8'h0001 : cnt_reg + 8'h0001;
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_reg           <= port_io_pkg::ST_IDLE;
      cls_reg             <= port_io_pkg::CLS_IN_BLOCK;
      dec_reg             <= 1'b0;
      rep_reg             <= 1'b0;
      a_reg               <= port_io_pkg::RST_BYTE;
      b_reg               <= port_io_pkg::RST_BYTE;
      port_reg            <= port_io_pkg::RST_BYTE;
      data_reg            <= port_io_pkg::RST_BYTE;
      f_reg               <= port_io_pkg::RST_BYTE;
      pointer_pair_reg    <= port_io_pkg::RST_WORD;
      program_counter_reg <= port_io_pkg::RST_WORD;
      done_reg            <= 1'b0;
      ill_reg             <= 1'b0;
      int_reg             <= 1'b0;
      addr_reg            <= port_io_pkg::RST_WORD;
      dout_reg            <= port_io_pkg::RST_BYTE;
      oe_reg              <= 1'b0;
      cnt_reg             <= port_io_pkg::RST_BYTE;
    end
    else
    begin
      state_reg           <= state_next;
      cls_reg             <= cls_next;
      dec_reg             <= dec_next;
      rep_reg             <= rep_next;
      a_reg               <= a_next;
      b_reg               <= b_next;
      port_reg            <= port_next;
      data_reg            <= data_next;
      f_reg               <= f_next;
      pointer_pair_reg    <= pointer_pair_next;
      program_counter_reg <= program_counter_next;
      done_reg            <= done_next;
      ill_reg             <= ill_next;
      int_reg             <= int_next;
      addr_reg            <= addr_next;
      dout_reg            <= dout_next;
      oe_reg              <= oe_next;
      cnt_reg             <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign BUSY                = (state_reg != port_io_pkg::ST_IDLE);
  assign DONE                = done_reg;
  assign ILLEGAL             = ill_reg;
  assign INT_TAKEN           = int_reg;
  assign OUT_B               = b_reg;
  assign OUT_POINTER_PAIR    = pointer_pair_reg;
  assign OUT_FLAGS           = f_reg;
  assign OUT_PROGRAM_COUNTER = program_counter_reg;
  assign ADDR                = addr_reg;
  assign DATA_OUT            = dout_reg;
  assign DATA_OE             = oe_reg;
  assign IORQ_N = !(state_reg == port_io_pkg::ST_IO_READ || state_reg == port_io_pkg::ST_IO_WRITE);
  assign RD_N   = !(state_reg == port_io_pkg::ST_IO_READ || state_reg == port_io_pkg::ST_MEM_READ);
  assign WR_N   = !(state_reg == port_io_pkg::ST_IO_WRITE || state_reg == port_io_pkg::ST_MEM_WRITE);
  // Two refresh strobes per repeated byte
  assign RFSH_N = !(state_reg == port_io_pkg::ST_REFRESH &&
                    (t_count == port_io_pkg::RFSH_POS_A || t_count == port_io_pkg::RFSH_POS_B));
  assign MREQ_N = !(state_reg == port_io_pkg::ST_MEM_READ ||
                    state_reg == port_io_pkg::ST_MEM_WRITE || !RFSH_N);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  logic ending;
  assign ending = BUSY && state_next == port_io_pkg::ST_IDLE &&
                  state_reg != port_io_pkg::ST_REFRESH;

  sequence s_two_strobes;
    RFSH_N ##1 !RFSH_N ##1 RFSH_N ##1 !RFSH_N ##1 RFSH_N;
  endsequence

  chk_io_read_addr: assert property (!IORQ_N && !RD_N |-> ADDR == {b_reg, port_reg})
    else $error("port read address wrong");
  chk_in_block_len: assert property (ending && cls_reg == port_io_pkg::CLS_IN_BLOCK
    |-> cnt_reg == 8'(port_io_pkg::TOT_IN_BLOCK))
    else $error("block input length wrong");
  chk_zero_flag: assert property (DONE && cls_reg == port_io_pkg::CLS_IN_BLOCK && !INT_TAKEN
    |-> OUT_FLAGS[port_io_pkg::FLAG_Z] == (OUT_B == 8'h0000) && OUT_FLAGS[port_io_pkg::FLAG_N])
    else $error("zero or subtract flag wrong");
  chk_prog_rewind: assert property (INT_TAKEN
    |-> OUT_PROGRAM_COUNTER == $past(program_counter_reg) - 16'h0002 && DONE)
    else $error("program counter not rewound");
  chk_refresh_pair: assert property (state_reg != port_io_pkg::ST_REFRESH &&
    state_next == port_io_pkg::ST_REFRESH |=> s_two_strobes)
    else $error("refresh strobes wrong");
  chk_counter_wrap: assert property (state_reg == port_io_pkg::ST_MEM_WRITE && t_last &&
    b_reg == 8'h0000 |=> b_reg == 8'h00FF)
    else $error("counter did not wrap");
  chk_imm_addr: assert property (!WR_N && !IORQ_N && cls_reg == port_io_pkg::CLS_OUT_IMM
    |-> ADDR == {a_reg, port_reg} && DATA_OUT == a_reg && DATA_OE)
    else $error("immediate output address or data wrong");
  chk_imm_len: assert property (ending && cls_reg == port_io_pkg::CLS_OUT_IMM
    |-> cnt_reg == 8'(port_io_pkg::TOT_OUT_IMM))
    else $error("immediate output length wrong");
  chk_reg_len: assert property (ending && cls_reg == port_io_pkg::CLS_OUT_REG
    |-> cnt_reg == 8'(port_io_pkg::TOT_OUT_REG) ##1 OUT_FLAGS == $past(f_reg, 2))
    else $error("register output length or flags wrong");
  chk_mem_write: assert property (!MREQ_N && !WR_N
    |-> ADDR == pointer_pair_reg && DATA_OUT == data_reg && DATA_OE)
    else $error("memory write wrong");
  chk_out_inc_high: assert property (!IORQ_N && cls_reg == port_io_pkg::CLS_OUT_INC
    |-> ADDR[15:8] == b_reg && $past(b_reg, 4) == b_reg + 8'h0001)
    else $error("output counter not decremented first");

endmodule : port_io_exec

`default_nettype wire

// ### design/port_io_pkg.sv
// Constants, opcodes, T-state lengths and state types for the port I/O executor.
// Assumes one T state per CLOCK edge and an external decoder that hands over two bytes.
// Behaviour
// - Register-port transfers put port register on A0-A7, counter on A8-A15.
// - in_inc_step reads port byte, stores at pointer_pair, counter-1, pointer_pair+1.
// - Single-step block input takes four machine cycles: 4, 5, 3, 4 T.
// - Block input sets Z if counter-1 is zero, sets N, keeps C.
// - ED B2 is in_inc_repeat and ED BA is in_dec_repeat.
// - ED AA is in_dec_step and ED A3 is out_inc_step.
// - Repeat loops while counter non-zero, else stops; subtracts two from program_counter only on interrupt.
// - Repeat input recognises interrupts and does two refresh cycles after each byte that leaves the counter non-zero.
// - A zero counter at repeat start moves 256 bytes.
// - in_dec_step stores port byte at pointer_pair, then decrements counter and pointer.
// - in_dec_repeat decrements pointer and counter per byte, then tests counter.
// - Immediate output drives operand on A0-A7, accumulator on A8-A15 and data.
// - Immediate output is D3 plus operand, 11 T as 4, 3, 4.
// - Register output field 000-101 picks B,C,D,E,H,L; 111 picks accumulator.
// - Register output takes 12 T as 4, 4, 4 and keeps all flags.
// - out_inc_step sends memory byte at pointer_pair to port, counter-1, pointer+1.
// - out_inc_step decrements counter before the port cycle, shown on A8-A15.

package port_io_pkg;

  localparam int          CLK_PERIOD_NS = 100;
  localparam logic [7:0]  OPC_PREFIX    = 8'h00ED;
  localparam logic [7:0]  OPC_IN_INC_S  = 8'h00A2;
  localparam logic [7:0]  OPC_IN_DEC_S  = 8'h00AA;
  localparam logic [7:0]  OPC_IN_INC_R  = 8'h00B2;
  localparam logic [7:0]  OPC_IN_DEC_R  = 8'h00BA;
  localparam logic [7:0]  OPC_OUT_INC_S = 8'h00A3;
  localparam logic [7:0]  OPC_OUT_IMM   = 8'h00D3;
  localparam logic [7:0]  OPC_REG_MASK  = 8'h00C7;
  localparam logic [7:0]  OPC_OUT_REG   = 8'h0041;
  localparam int          OPC_DEC_BIT   = 3;
  localparam int          OPC_REP_BIT   = 4;
  localparam logic [2:0]  SEL_B         = 3'h0;
  localparam logic [2:0]  SEL_C         = 3'h1;
  localparam logic [2:0]  SEL_D         = 3'h2;
  localparam logic [2:0]  SEL_E         = 3'h3;
  localparam logic [2:0]  SEL_H         = 3'h4;
  localparam logic [2:0]  SEL_L         = 3'h5;
  localparam logic [2:0]  SEL_A         = 3'h7;
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_N        = 1;
  localparam int          FLAG_Z        = 6;
  localparam logic [2:0]  LEN_FETCH     = 3'h4;
  localparam logic [2:0]  LEN_FETCH_BLK = 3'h5;
  localparam logic [2:0]  LEN_OPERAND   = 3'h3;
  localparam logic [2:0]  LEN_FETCH_REG = 3'h4;
  localparam logic [2:0]  LEN_IO_READ   = 3'h3;
  localparam logic [2:0]  LEN_MEM_WRITE = 3'h4;
  localparam logic [2:0]  LEN_MEM_READ  = 3'h3;
  localparam logic [2:0]  LEN_IO_WRITE  = 3'h4;
  localparam logic [2:0]  LEN_REFRESH   = 3'h5;
  localparam logic [2:0]  RFSH_POS_A    = 3'h4;
  localparam logic [2:0]  RFSH_POS_B    = 3'h2;
  localparam int          TOT_IN_BLOCK  = 16;
  localparam int          TOT_OUT_IMM   = 11;
  localparam int          TOT_OUT_REG   = 12;
  localparam logic [7:0]  RST_BYTE      = 8'h0000;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [15:0] PROG_REWIND   = 16'h0002;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_FETCH1    = 3'b001,
    ST_FETCH2    = 3'b010,
    ST_IO_READ   = 3'b011,
    ST_MEM_WRITE = 3'b100,
    ST_MEM_READ  = 3'b101,
    ST_IO_WRITE  = 3'b110,
    ST_REFRESH   = 3'b111
  } state_t;

  typedef enum logic [1:0] {
    CLS_IN_BLOCK = 2'b00,
    CLS_OUT_INC  = 2'b01,
    CLS_OUT_IMM  = 2'b10,
    CLS_OUT_REG  = 2'b11
  } class_t;

endpackage : port_io_pkg

// ### design/tstate_timer.sv
// Down-counter that times the T states of one machine cycle.
// Assumes load is asserted in the cycle before a new machine cycle begins.
`timescale 1ns/1ns
`default_nettype none

module tstate_timer #(
  parameter int W = 3
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] len,
  output logic      [W-1:0] count,
  output logic              last
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  if (W < 3)
  begin : g_check
    $error("tstate_timer needs at least 3 bits");
  end

  always_comb
  begin
    if (load)
      count_next = len;
    else if (count_reg != '0)
      count_next = count_reg - W'(1);
    else
      count_next = count_reg;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign count = count_reg;
  assign last  = (count_reg == W'(1));

endmodule : tstate_timer

`default_nettype wire

// ### testbench/cpu_port_io_instructions_test.sv
// Self-checking bench for the port I/O executor.
// Assumes periph_model answers port reads with the upper address byte XOR 3C.
`timescale 1ns/1ns
`default_nettype none
module cpu_port_io_instructions_test;
  logic        clock = 1'b0, rstn = 1'b0, start = 1'b0, intp = 1'b0;
  logic [7:0]  op0 = 8'h00, op1 = 8'h00, a = 8'h00, b = 8'h00, c = 8'h00, fl = 8'h00;
  logic [7:0]  d = 8'h33, e = 8'h44, out_b, out_fl, din, dout;
  logic [15:0] ptr = 16'h0000, prog = 16'h0000, out_ptr, out_prog, addr;
  logic        busy, done, ill, itk, oe, mreq_n, iorq_n, rd_n, wr_n, rfsh_n;
  int          errors = 0, check_count = 0, cyc = 0;
  port_io_exec port_io_exec_inst (.CLOCK(clock), .RSTN(rstn), .START(start),
    .OP_BYTE0(op0), .OP_BYTE1(op1), .IN_A(a), .IN_B(b), .IN_C(c), .IN_D(d), .IN_E(e),
    .IN_POINTER_PAIR(ptr), .IN_FLAGS(fl), .IN_PROGRAM_COUNTER(prog), .INT_PENDING(intp),
    .DATA_IN(din), .BUSY(busy), .DONE(done), .ILLEGAL(ill), .INT_TAKEN(itk), .OUT_B(out_b),
    .OUT_POINTER_PAIR(out_ptr), .OUT_FLAGS(out_fl), .OUT_PROGRAM_COUNTER(out_prog), .ADDR(addr),
    .DATA_OUT(dout), .DATA_OE(oe), .MREQ_N(mreq_n), .IORQ_N(iorq_n), .RD_N(rd_n),
    .WR_N(wr_n), .RFSH_N(rfsh_n));
  periph_model periph_model_inst (.CLOCK(clock), .ADDR(addr), .DATA_OUT(dout),
    .MREQ_N(mreq_n), .IORQ_N(iorq_n), .RD_N(rd_n), .WR_N(wr_n), .DATA_IN(din));
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic ld(input logic [7:0] nb, nc, input logic [15:0] nhl, input logic [7:0] nf);
    @(posedge clock);
    b <= nb;
    c <= nc;
    ptr <= nhl;
    fl <= nf;
  endtask : ld
  // Issues one instruction and expects DONE at the nth falling edge after the taken edge
  task automatic run(input logic [7:0] p, q, input int n);
    int k;
    k = 0;
    op0 <= p;
    op1 <= q;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    do
    begin
      @(negedge clock);
      k++;
    end
    while (done !== 1'b1 && k < 6000);
    chk(k == n, "latency");
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_step;
    ld(8'h10, 8'h07, 16'h1000, 8'h01);
    run(8'hED, 8'hA2, 17);
    chk(out_b === 8'h0F && out_ptr === 16'h1001, "inc regs");
    chk(periph_model_inst.mem[16'h1000] === 8'h2C, "inc store");
    chk(out_fl[6] === 1'b0 && out_fl[1] === 1'b1 && out_fl[0] === 1'b1, "inc flags");
    ld(8'h01, 8'h07, 16'h1000, 8'h00);
    run(8'hED, 8'hAA, 17);
    chk(out_b === 8'h00 && out_ptr === 16'h0FFF, "dec regs");
    chk(periph_model_inst.mem[16'h1000] === 8'h3D, "dec store");
    chk(out_fl[6] === 1'b1 && out_fl[0] === 1'b0, "dec flags");
    $display("t_step end");
  endtask : t_step
  task automatic t_rep;
    for (int i = 0; i < 2; i++)
    begin
      ld(8'h03, 8'h07, 16'h1000, 8'h00);
      run(8'hED, i ? 8'hBA : 8'hB2, 59);
      chk(out_b === 8'h00 && out_ptr === (i ? 16'h0FFD : 16'h1003), "rep regs");
      chk(out_fl[6] === 1'b1 && out_fl[1] === 1'b1, "rep flags");
      chk(periph_model_inst.mem[i ? 16'h0FFE : 16'h1002] === 8'h3D, "rep store");
    end
    ld(8'h00, 8'h07, 16'hFFFF, 8'h00);
    run(8'hED, 8'hB2, 5372);
    chk(out_b === 8'h00 && out_ptr === 16'h00FF, "wrap regs");
    chk(periph_model_inst.mem[16'h0000] === 8'hC3, "wrap store");
    ld(8'h05, 8'h07, 16'h3000, 8'h00);
    intp <= 1'b1;
    prog <= 16'h4000;
    run(8'hED, 8'hB2, 22);
    chk(itk === 1'b1 && out_b === 8'h04 && out_prog === 16'h3FFE, "int stop");
    @(posedge clock);
    intp <= 1'b0;
    $display("t_rep end");
  endtask : t_rep
  task automatic t_out;
    logic [7:0] rv [8];
    rv = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h00, 8'h77};
    periph_model_inst.mem[16'h2000] = 8'h59;
    ld(8'h10, 8'h07, 16'h2000, 8'h01);
    run(8'hED, 8'hA3, 17);
    chk(periph_model_inst.port_addr === 16'h0F07, "out inc addr");
    chk(periph_model_inst.port_data === 8'h59 && out_ptr === 16'h2001, "out inc data");
    ld(8'h10, 8'h07, 16'h2000, 8'hC5);
    a <= 8'h23;
    run(8'hD3, 8'h01, 12);
    chk(periph_model_inst.port_addr === 16'h2301, "imm addr");
    chk(periph_model_inst.port_data === 8'h23 && out_fl === 8'hC5, "imm data");
    for (int r = 0; r < 8; r++)
    begin
      if (r != 6)
      begin
        ld(8'h11, 8'h22, 16'h5566, 8'hC5);
        a <= 8'h77;
        run(8'hED, {2'b01, 3'(r), 3'b001}, 13);
        chk(periph_model_inst.port_addr === 16'h1122, "reg addr");
        chk(periph_model_inst.port_data === rv[r], "reg data");
        chk(out_fl === 8'hC5, "reg flags");
      end
    end
    ld(8'h11, 8'h22, 16'h5566, 8'hC5);
    op0 <= 8'hED;
    op1 <= 8'h71;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    chk(ill === 1'b1 && busy === 1'b0, "reg field 110 accepted");
    $display("t_out end");
  endtask : t_out
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 9000)
    begin
      errors++;
      stop_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    t_step();
    t_rep();
    t_out();
    stop_test();
  end
endmodule : cpu_port_io_instructions_test
`default_nettype wire

// ### testbench/periph_model.sv
// Port and memory model on the far side of the executor.
// Assumes active-low strobes, sampled at the CLOCK rise.
`timescale 1ns/1ns
`default_nettype none
module periph_model (
  input  wire logic        CLOCK,
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  DATA_OUT,
  input  wire logic        MREQ_N,
  input  wire logic        IORQ_N,
  input  wire logic        RD_N,
  input  wire logic        WR_N,
  output logic      [7:0]  DATA_IN
);
  logic [7:0]  mem [0:65535];
  logic [15:0] port_addr;
  logic [7:0]  port_data;
  // Port byte follows the upper address half; released bus shows no stale value
  assign DATA_IN = (!RD_N && !IORQ_N) ? ADDR[15:8] ^ 8'h3C :
                   (!RD_N && !MREQ_N) ? mem[ADDR] : ~ADDR[7:0];
  always @(posedge CLOCK)
  begin
    if (!WR_N && !MREQ_N)
      mem[ADDR] <= DATA_OUT;
    if (!WR_N && !IORQ_N)
    begin
      port_addr <= ADDR;
      port_data <= DATA_OUT;
    end
  end
endmodule : periph_model
`default_nettype wire
